// >>> verilog/lidar_link_defines.vh
// Purpose: Shared constants for the IO-Link status and teach-in block
// Assumes: 50 MHz clock, command values arrive as bytes
// Notes:   Times are kept in their own units; cycle counts derive in the top module
`ifndef LIDAR_LINK_DEFINES_VH
`define LIDAR_LINK_DEFINES_VH

// Command index and command values
`define CMD_INDEX         8'h02
`define CMD_TEACH_F1      8'h41
`define CMD_TEACH_F2      8'h42
`define CMD_RESTORE       8'h82
`define CMD_SAVE          8'hE1
`define CMD_CLR_CNT_F1    8'hE2
`define CMD_CLR_RES_F1    8'hE3
`define CMD_CLR_CNT_F2    8'hE5
`define CMD_CLR_RES_F2    8'hE6

// Status word layout
`define SW_OUT1_BIT       0
`define SW_OUT2_BIT       1
`define SW_LOWSPARE_LSB   2
`define SW_STATE_LSB      4
`define SW_STATE_MSB      7
`define SW_UPSPARE_LSB    8
`define SW_RESET          16'h0000

// Device state codes
`define DS_UNKNOWN        4'h0
`define DS_STARTUP        4'h1
`define DS_SERVICE_MODE   4'h2
`define DS_NORMAL         4'h3
`define DS_SUSPENDED      4'h4
`define DS_SVC_RECOMMEND  4'h5
`define DS_SVC_REQUIRED   4'h6
`define DS_RECOVERABLE    4'h7
`define DS_FATAL          4'h8

// Teach-in figures
`define CLK_HZ            50000000
`define CLEAR_WINDOW_S    8'h0F
`define FORM_TIME_S       8'h01
`define TEACH_DEFAULT_S   8'h1E
`define TEACH_MIN_S       8'h0A
`define BLINK_HALF_MS     250
`define FIELD_OFFSET_MM   16'h00FA
`define ANGLE_START_DEF   9'h19C
`define ANGLE_STOP_DEF    9'h064
`define ANGLE_BIAS        8'h64
`define ANGLE_COUNT       201

`endif

// >>> verilog/sample_fifo.v
// Purpose: Valid/ready FIFO for scan samples
// Assumes: Single clock, synchronous active-high reset
// Notes:   Output word comes from a register; one extra word of room in that register
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 25,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Fill side
  input  wire             inValid,
  output reg              inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output reg              outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr_r;
  reg  [AW-1:0]    rdPtr_r;
  reg  [AW:0]      memCnt_r;
  reg  [AW:0]      memCnt_nxt;
  wire             wrFire;
  wire             load;

  assign wrFire = inValid & inReady;
  assign load   = (memCnt_r != {(AW+1){1'b0}}) & (~outValid | outReady);

  always @*
  begin
    memCnt_nxt = memCnt_r;
    if (wrFire & ~load)
      memCnt_nxt = memCnt_r + 1'b1;
    else if (load & ~wrFire)
      memCnt_nxt = memCnt_r - 1'b1;
  end

  always @(posedge clock)
  begin
    if (wrFire)
      mem[wrPtr_r] <= inData;
    if (load)
      outData <= mem[rdPtr_r];
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      wrPtr_r  <= {AW{1'b0}};
      rdPtr_r  <= {AW{1'b0}};
      memCnt_r <= {(AW+1){1'b0}};
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (wrFire)
        wrPtr_r <= (wrPtr_r == DEPTH-1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      if (load)
        rdPtr_r <= (rdPtr_r == DEPTH-1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      memCnt_r <= memCnt_nxt;
      // Registered ready: full is known one cycle ahead from the next count
      inReady  <= (memCnt_nxt != DEPTH);
      if (load)
        outValid <= 1'b1;
      else if (outReady)
        outValid <= 1'b0;
    end
  end
endmodule // sample_fifo

// >>> verilog/lidar_link_status_teach.v
// Purpose: Cyclic status word, command decode and field teach-in sequencing
// Assumes: All inputs synchronous to clock; limit store answers a read one cycle later
// Notes:   Field limits live outside; this block does the min-merge over its ports
//
// Operation
// - Send a sixteen-bit unsigned status word from sensor toward master.
// - Layout: spare byte 15..8, state 7..4, spare pair 3..2, outputs 1 and 0.
// - State codes: unknown 0, start-up 1, service 2, normal 3, suspended 4.
// - Codes: recommend 5, required 6, recoverable 7, fatal 8; nothing above 8.
// - Teach may start from the wired input, the tool or a command.
// - As delivered, teach activation comes from the wired teach input.
// - One field teaches at a time; wired teach targets field one.
// - Default teach angles span minus one hundred to plus one hundred degrees.
// - Teach lasts thirty seconds by default; durations under ten are rejected.
// - On start, blink green through a fifteen-second clearing window.
// - Field boundary is measured contour less a 250 mm offset.
// - While forming the field, green and red are lit together.
// - Keep each angle's minimum distance as its field limit.
// - Blink green while recording, steady green once recording finishes.
// - Command 65 teaches field one, command 66 teaches field two.
// - Command 225 commits taught fields to non-volatile storage.
// - Command 226 clears field one counter, 229 clears field two counter.
// - Command 227 clears field one result, 230 clears field two result.
// - Report service mode whenever no detection field is configured; start-up, faults and service required take priority over it.
`timescale 1ns/1ps
`include "lidar_link_defines.vh"
module lidar_link_status_teach #(
  parameter [31:0] SEC_CYCLES        = `CLK_HZ,
  parameter [31:0] BLINK_HALF_CYCLES = `BLINK_HALF_MS * (`CLK_HZ / 1000),
  parameter        FIFO_DEPTH        = 32,
  parameter        FIFO_AW           = 5
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst,
  // Command write from the link
  input  wire              cmdWrite,
  input  wire [7:0]        cmdIndex,
  input  wire [7:0]        cmdValue,
  // Cyclic status word
  output reg  [15:0]       statusWord,
  // Field evaluation and health
  input  wire              fieldHit1,
  input  wire              fieldHit2,
  input  wire              faultFatal,
  input  wire              faultRecoverable,
  input  wire              serviceRequired,
  input  wire              serviceRecommended,
  input  wire              suspendRequest,
  input  wire              storedFieldPresent,
  // Teach configuration and requests
  input  wire              teachRequestInput,
  input  wire              wiredTeachOff,
  input  wire              toolTeachStart,
  input  wire              toolTeachField,
  input  wire [7:0]        teachDurationCfg,
  input  wire              angleCfgEnable,
  input  wire signed [8:0] startAngleCfg,
  input  wire signed [8:0] stopAngleCfg,
  // Scan samples
  input  wire              sampleValid,
  output wire              sampleReady,
  input  wire signed [8:0] sampleAngle,
  input  wire [15:0]       sampleDist,
  // Field limit store
  output reg               limitRdEn,
  output reg  [7:0]        limitAddr,
  input  wire [15:0]       limitRdData,
  output reg               limitWrEn,
  output reg               limitWrField,
  output reg  [15:0]       limitWrData,
  // Switching outputs, indicators and status
  output reg               switchOutputOne,
  output reg               switchOutputTwo,
  output reg               ledGreen,
  output reg               ledRed,
  output reg               teachActive,
  output reg               teachField,
  output reg               durationRejected,
  output reg               saveStrobe,
  output reg               restoreStrobe,
  output reg  [15:0]       counterOne,
  output reg  [15:0]       counterTwo
);
  localparam [2:0] T_IDLE   = 3'h0;
  localparam [2:0] T_CLEAR  = 3'h1;
  localparam [2:0] T_FORM   = 3'h2;
  localparam [2:0] T_RECORD = 3'h3;

  reg  [2:0]        tState_r;
  reg  [2:0]        tState_nxt;
  reg               wiredSession_r;
  reg               teachInPrev_r;
  reg  [31:0]       secCnt_r;
  reg  [7:0]        secElapsed_r;
  reg  [31:0]       blinkCnt_r;
  reg               blink_r;
  reg               bootDone_r;
  reg               fieldCfg1_r;
  reg               fieldCfg2_r;
  reg               hitPrev1_r;
  reg               hitPrev2_r;
  reg  [1:0]        recPh_r;
  reg  [15:0]       cand_r;
  reg  [`ANGLE_COUNT-1:0] seen_r;
  reg  [3:0]        devState;
  reg  [15:0]       mergeVal;
  reg  [7:0]        effDur;
  reg               startReq;
  reg               startField;
  reg               startWired;

  wire              cmdHit;
  wire              secTick;
  wire              fifoValid;
  wire              fifoReady;
  wire [24:0]       fifoData;
  wire signed [8:0] fAngle;
  wire [15:0]       fDist;
  wire signed [8:0] angleLo;
  wire signed [8:0] angleHi;
  wire              recording;
  wire              inRange;

  // Counter step with the set-wins-over-clear policy
  function [15:0] count_step;
    input [15:0] cnt;
    input        inc;
    input        clr;
    begin
      if (clr)
        count_step = inc ? 16'h0001 : 16'h0000;
      else if (inc)
        count_step = cnt + 16'h0001;
      else
        count_step = cnt;
    end
  endfunction

  // Contour less offset, saturating at zero
  function [15:0] less_offset;
    input [15:0] d;
    begin
      less_offset = (d > `FIELD_OFFSET_MM) ? d - `FIELD_OFFSET_MM : 16'h0000;
    end
  endfunction

  assign cmdHit    = cmdWrite & (cmdIndex == `CMD_INDEX);
  assign secTick   = (secCnt_r == SEC_CYCLES - 1);
  assign fAngle    = fifoData[24:16];
  assign fDist     = fifoData[15:0];
  assign angleLo   = angleCfgEnable ? startAngleCfg : `ANGLE_START_DEF;
  assign angleHi   = angleCfgEnable ? stopAngleCfg : `ANGLE_STOP_DEF;
  assign inRange   = (fAngle >= angleLo) & (fAngle <= angleHi) &
                     (fAngle >= $signed(`ANGLE_START_DEF)) & (fAngle <= $signed(`ANGLE_STOP_DEF));
  assign recording = (tState_r == T_FORM) | (tState_r == T_RECORD);
  // Drain stalls during each read-merge-write so back-pressure reaches the source
  assign fifoReady = (recPh_r == 2'b00);

  sample_fifo #(
    .WIDTH    (25),
    .DEPTH    (FIFO_DEPTH),
    .AW       (FIFO_AW)
  ) u_sample_fifo (
    .clock    (clock),
    .rst      (rst),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   ({sampleAngle, sampleDist}),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  // Teach start arbitration: command, then tool, then wired edge
  always @*
  begin
    startReq   = 1'b0;
    startField = 1'b0;
    startWired = 1'b0;
    if (cmdHit & (cmdValue == `CMD_TEACH_F1))
      startReq = 1'b1;
    else if (cmdHit & (cmdValue == `CMD_TEACH_F2))
    begin
      startReq   = 1'b1;
      startField = 1'b1;
    end
    else if (toolTeachStart)
    begin
      startReq   = 1'b1;
      startField = toolTeachField;
    end
    else if (~wiredTeachOff & teachRequestInput & ~teachInPrev_r)
    begin
      startReq   = 1'b1;
      startWired = 1'b1;
    end
  end

  // Durations below the minimum fall back to the default
  always @*
  begin
    if (teachDurationCfg < `TEACH_MIN_S)
      effDur = `TEACH_DEFAULT_S;
    else
      effDur = teachDurationCfg;
  end

  always @*
  begin
    tState_nxt = tState_r;
    case (tState_r)
      T_IDLE:
        if (startReq)
          tState_nxt = T_CLEAR;
      T_CLEAR:
        if (secTick & (secElapsed_r == `CLEAR_WINDOW_S - 8'h01))
          tState_nxt = T_FORM;
      T_FORM:
        if (secTick & (secElapsed_r == `FORM_TIME_S - 8'h01))
          tState_nxt = T_RECORD;
      T_RECORD:
        if (wiredSession_r ? ~teachRequestInput
                           : (secTick & (secElapsed_r >= effDur - 8'h01)))
          tState_nxt = T_IDLE;
      default:
        tState_nxt = T_IDLE;
    endcase
  end

  // Device state priority: start-up first, then faults, then service conditions
  always @*
  begin
    if (~bootDone_r)
      devState = `DS_STARTUP;
    else if (faultFatal)
      devState = `DS_FATAL;
    else if (faultRecoverable)
      devState = `DS_RECOVERABLE;
    else if (serviceRequired)
      devState = `DS_SVC_REQUIRED;
    else if (~(fieldCfg1_r | fieldCfg2_r | storedFieldPresent))
      devState = `DS_SERVICE_MODE;
    else if (suspendRequest)
      devState = `DS_SUSPENDED;
    else if (serviceRecommended)
      devState = `DS_SVC_RECOMMEND;
    else
      devState = `DS_NORMAL;
  end

  // Unseen angles take the candidate; seen ones keep the smaller value
  always @*
  begin
    if (~seen_r[limitAddr] | (cand_r < limitRdData))
      mergeVal = cand_r;
    else
      mergeVal = limitRdData;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      tState_r         <= T_IDLE;
      wiredSession_r   <= 1'b0;
      teachInPrev_r    <= 1'b0;
      secCnt_r         <= 32'h00000000;
      secElapsed_r     <= 8'h00;
      blinkCnt_r       <= 32'h00000000;
      blink_r          <= 1'b0;
      bootDone_r       <= 1'b0;
      fieldCfg1_r      <= 1'b0;
      fieldCfg2_r      <= 1'b0;
      hitPrev1_r       <= 1'b0;
      hitPrev2_r       <= 1'b0;
      recPh_r          <= 2'b00;
      cand_r           <= 16'h0000;
      seen_r           <= {`ANGLE_COUNT{1'b0}};
      statusWord       <= `SW_RESET;
      limitRdEn        <= 1'b0;
      limitAddr        <= 8'h00;
      limitWrEn        <= 1'b0;
      limitWrField     <= 1'b0;
      limitWrData      <= 16'h0000;
      switchOutputOne  <= 1'b0;
      switchOutputTwo  <= 1'b0;
      ledGreen         <= 1'b0;
      ledRed           <= 1'b0;
      teachActive      <= 1'b0;
      teachField       <= 1'b0;
      durationRejected <= 1'b0;
      saveStrobe       <= 1'b0;
      restoreStrobe    <= 1'b0;
      counterOne       <= 16'h0000;
      counterTwo       <= 16'h0000;
    end
    else
    begin
      bootDone_r       <= 1'b1;
      teachInPrev_r    <= teachRequestInput;
      tState_r         <= tState_nxt;
      teachActive      <= (tState_nxt != T_IDLE);
      durationRejected <= (teachDurationCfg != 8'h00) & (teachDurationCfg < `TEACH_MIN_S);

      // Second prescaler restarts at every phase change so windows are whole seconds
      if (tState_nxt != tState_r)
      begin
        secCnt_r     <= 32'h00000000;
        secElapsed_r <= 8'h00;
      end
      else if (secTick)
      begin
        secCnt_r     <= 32'h00000000;
        secElapsed_r <= secElapsed_r + 8'h01;
      end
      else
        secCnt_r <= secCnt_r + 32'h00000001;

      if (blinkCnt_r == BLINK_HALF_CYCLES - 1)
      begin
        blinkCnt_r <= 32'h00000000;
        blink_r    <= ~blink_r;
      end
      else
        blinkCnt_r <= blinkCnt_r + 32'h00000001;

      if ((tState_r == T_IDLE) & startReq)
      begin
        teachField     <= startField;
        wiredSession_r <= startWired;
        seen_r         <= {`ANGLE_COUNT{1'b0}};
      end

      // A finished teach marks its field as configured
      if ((tState_r == T_RECORD) & (tState_nxt == T_IDLE))
      begin
        if (teachField)
          fieldCfg2_r <= 1'b1;
        else
          fieldCfg1_r <= 1'b1;
      end
      else if (cmdHit & (cmdValue == `CMD_RESTORE))
        fieldCfg1_r <= 1'b1;

      // Indicators; an error shown in red keeps green dark
      case (tState_r)
        T_CLEAR:
        begin
          ledGreen <= blink_r;
          ledRed   <= 1'b0;
        end
        T_FORM:
        begin
          ledGreen <= 1'b1;
          ledRed   <= 1'b1;
        end
        T_RECORD:
        begin
          ledGreen <= blink_r;
          ledRed   <= 1'b0;
        end
        default:
        begin
          ledGreen <= ~(faultFatal | faultRecoverable | serviceRequired);
          ledRed   <= faultFatal | faultRecoverable | serviceRequired;
        end
      endcase

      // Sample merge pipeline: pop, read, then write the smaller limit
      limitRdEn <= 1'b0;
      limitWrEn <= 1'b0;
      case (recPh_r)
        2'b00:
          if (fifoValid & recording & inRange)
          begin
            limitAddr <= fAngle[7:0] + `ANGLE_BIAS;
            cand_r    <= less_offset(fDist);
            limitRdEn <= 1'b1;
            recPh_r   <= 2'b01;
          end
        2'b01:
          recPh_r <= 2'b10;
        2'b10:
        begin
          limitWrEn         <= 1'b1;
          limitWrField      <= teachField;
          limitWrData       <= mergeVal;
          seen_r[limitAddr] <= 1'b1;
          recPh_r           <= 2'b00;
        end
        default:
          recPh_r <= 2'b00;
      endcase

      // Results: a hit in the clearing cycle keeps the result set
      hitPrev1_r      <= switchOutputOne;
      hitPrev2_r      <= switchOutputTwo;
      if (fieldHit1)
        switchOutputOne <= 1'b1;
      else if (cmdHit & (cmdValue == `CMD_CLR_RES_F1))
        switchOutputOne <= 1'b0;
      if (fieldHit2)
        switchOutputTwo <= 1'b1;
      else if (cmdHit & (cmdValue == `CMD_CLR_RES_F2))
        switchOutputTwo <= 1'b0;

      counterOne <= count_step(counterOne, switchOutputOne & ~hitPrev1_r,
                               cmdHit & (cmdValue == `CMD_CLR_CNT_F1));
      counterTwo <= count_step(counterTwo, switchOutputTwo & ~hitPrev2_r,
                               cmdHit & (cmdValue == `CMD_CLR_CNT_F2));

      saveStrobe    <= cmdHit & (cmdValue == `CMD_SAVE);
      restoreStrobe <= cmdHit & (cmdValue == `CMD_RESTORE);

      statusWord <= 16'h0000;
      statusWord[`SW_STATE_MSB:`SW_STATE_LSB] <= devState;
      statusWord[`SW_OUT2_BIT] <= switchOutputTwo;
      statusWord[`SW_OUT1_BIT] <= switchOutputOne;
    end
  end
endmodule // lidar_link_status_teach

// >>> bench/link_master_model.sv
// Purpose: Link master stand-in that issues command writes
// Assumes: Called just after a rising clock edge
// Notes:   Released lines show inverted values so stale data never looks valid
`timescale 1ns/1ps
module link_master_model (
  // Clock
  input  wire       clock,
  // Command write
  output reg        cmdWrite,
  output reg  [7:0] cmdIndex,
  output reg  [7:0] cmdValue
);
  initial
  begin
    cmdWrite = 1'b0;
    cmdIndex = 8'h00;
    cmdValue = 8'h00;
  end

  // An idle edge first, so back-to-back calls never retoggle the strobe in one step
  task send(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clock);
    #1;
    cmdWrite = 1'b1;
    cmdIndex = idx;
    cmdValue = val;
    @(posedge clock);
    #1;
    cmdWrite = 1'b0;
    cmdIndex = ~idx;
    cmdValue = ~val;
  endtask
endmodule // link_master_model

// >>> bench/lidar_link_status_teach_assertions.sv
// Purpose: Port-level checks of status word, commands and limit updates
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`include "lidar_link_defines.vh"
module link_status_checker (
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Commands
  input wire        cmdWrite,
  input wire [7:0]  cmdIndex,
  input wire [7:0]  cmdValue,
  // Observed ports
  input wire [15:0] statusWord,
  input wire        fieldHit1,
  input wire        switchOutputOne,
  input wire        switchOutputTwo,
  input wire        teachActive,
  input wire        teachField,
  input wire [7:0]  teachDurationCfg,
  input wire        durationRejected,
  input wire        saveStrobe,
  input wire [15:0] counterOne,
  input wire        limitRdEn,
  input wire        limitWrEn
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  wire cmdTaken = cmdWrite && cmdIndex == `CMD_INDEX;

  sequence teachCmd;
    cmdTaken && (cmdValue == `CMD_TEACH_F1 || cmdValue == `CMD_TEACH_F2) && !teachActive;
  endsequence

  // Read answer lands one cycle later, merged value goes back the cycle after
  sequence readThenWrite;
    ##1 !limitWrEn ##1 limitWrEn;
  endsequence

  sequence hitQuiet;
    !fieldHit1 && !$past(fieldHit1) && !$past(fieldHit1, 2);
  endsequence

  AST_SPARE_ZERO: assert property (statusWord[15:8] == 8'h00 && statusWord[3:2] == 2'h0)
    else $error("Spare status bits not zero");
  AST_STATE_RANGE: assert property (statusWord[7:4] <= 4'h8)
    else $error("Device state above eight");
  AST_OUT_MAP: assert property (statusWord[1:0] == $past({switchOutputTwo, switchOutputOne}))
    else $error("Output bits do not follow switching outputs");
  AST_SAVE_PULSE: assert property (cmdTaken && cmdValue == `CMD_SAVE |=> saveStrobe)
    else $error("Save command gave no strobe");
  AST_SAVE_CAUSE: assert property (saveStrobe |-> $past(cmdTaken && cmdValue == `CMD_SAVE))
    else $error("Save strobe without save command");
  AST_TEACH_START: assert property (teachCmd |=> teachActive && teachField == $past(cmdValue[1]))
    else $error("Teach command did not start the right field");
  AST_RES1_CLEAR: assert property (cmdTaken && cmdValue == `CMD_CLR_RES_F1 ##0 hitQuiet |=> !switchOutputOne)
    else $error("Result one not cleared");
  AST_CNT1_CLEAR: assert property (cmdTaken && cmdValue == `CMD_CLR_CNT_F1 ##0 hitQuiet |=> counterOne == 16'h0000)
    else $error("Counter one not cleared");
  AST_DUR_REJECT: assert property ($stable(teachDurationCfg) [*3]
    |-> durationRejected == (teachDurationCfg != 8'h00 && teachDurationCfg < `TEACH_MIN_S))
    else $error("Duration reject flag wrong");
  AST_RD_WR: assert property (limitRdEn |-> readThenWrite)
    else $error("Limit read not followed by write two cycles later");
endmodule // link_status_checker

bind lidar_link_status_teach link_status_checker chk (
  .clock(clock), .rst(rst), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex), .cmdValue(cmdValue),
  .statusWord(statusWord), .fieldHit1(fieldHit1), .switchOutputOne(switchOutputOne),
  .switchOutputTwo(switchOutputTwo), .teachActive(teachActive), .teachField(teachField),
  .teachDurationCfg(teachDurationCfg), .durationRejected(durationRejected), .saveStrobe(saveStrobe),
  .counterOne(counterOne), .limitRdEn(limitRdEn), .limitWrEn(limitWrEn));

// >>> bench/tb_lidar_link_status_teach.sv
// Purpose: Self-checking bench for status word, commands and teach-in
// Assumes: Shortened time base, 20 cycles a second and 4 a blink half
// Notes:   Limit store lives here; the master model issues commands
`timescale 1ns/1ps
`include "lidar_link_defines.vh"
`define CHECK_EQ(got, exp) begin testsRun++; if ((got) !== (exp)) begin nMismatch++; \
  $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
`define WAIT_UNTIL(c) begin k = 0; while (!(c) && k < 400) begin tick(1); k++; end `CHECK_EQ(c, 1'b1) end
module tb_lidar_link_status_teach;
  logic              clock, rst, teachRequestInput, toolTeachStart, toolTeachField, sampleValid;
  logic [1:0]        hits, cfg;
  logic [4:0]        health;
  logic [7:0]        teachDurationCfg, nWr;
  logic signed [8:0] sampleAngle;
  logic [15:0]       sampleDist, limitRdData;
  logic [15:0]       mem [0:255];
  wire               cmdWrite, sampleReady, limitRdEn, limitWrEn, limitWrField, switchOutputOne, switchOutputTwo;
  wire               ledGreen, ledRed, teachActive, teachField, durationRejected, saveStrobe, restoreStrobe;
  wire [7:0]         cmdIndex, cmdValue, limitAddr;
  wire [15:0]        statusWord, limitWrData, counterOne, counterTwo;
  int                nMismatch, testsRun, cyc, k, n, g, t0;

  link_master_model master (.clock(clock), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex), .cmdValue(cmdValue));
  lidar_link_status_teach #(.SEC_CYCLES(32'h14), .BLINK_HALF_CYCLES(32'h4)) dut (
    .clock(clock), .rst(rst), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex), .cmdValue(cmdValue),
    .statusWord(statusWord), .fieldHit1(hits[0]), .fieldHit2(hits[1]), .faultFatal(health[4]),
    .faultRecoverable(health[3]), .serviceRequired(health[2]), .serviceRecommended(health[1]),
    .suspendRequest(health[0]), .storedFieldPresent(cfg[1]), .teachRequestInput(teachRequestInput),
    .wiredTeachOff(cfg[0]), .toolTeachStart(toolTeachStart), .toolTeachField(toolTeachField),
    .teachDurationCfg(teachDurationCfg), .angleCfgEnable(1'b0), .startAngleCfg(9'h000), .stopAngleCfg(9'h000),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleAngle(sampleAngle), .sampleDist(sampleDist),
    .limitRdEn(limitRdEn), .limitAddr(limitAddr), .limitRdData(limitRdData), .limitWrEn(limitWrEn),
    .limitWrField(limitWrField), .limitWrData(limitWrData), .switchOutputOne(switchOutputOne),
    .switchOutputTwo(switchOutputTwo), .ledGreen(ledGreen), .ledRed(ledRed), .teachActive(teachActive),
    .teachField(teachField), .durationRejected(durationRejected), .saveStrobe(saveStrobe),
    .restoreStrobe(restoreStrobe), .counterOne(counterOne), .counterTwo(counterTwo));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Read data is only valid the cycle after a read; otherwise it shows garbage
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    limitRdData <= limitRdEn ? mem[limitAddr] : ~limitRdData;
    if (limitWrEn)
    begin
      mem[limitAddr] <= limitWrData;
      nWr <= nWr + 8'h01;
    end
  end

  task tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  task push(input logic signed [8:0] a, input logic [15:0] d);
    sampleValid = 1'b1;
    sampleAngle = a;
    sampleDist = d;
    `WAIT_UNTIL(sampleReady === 1'b1)
    tick(1);
    sampleValid = 1'b0;
    sampleAngle = ~a;
    sampleDist = ~d;
    tick(1);
  endtask

  // Red adds a hundred so it cannot hide inside the green count
  task greenSum(input int c);
    {n, g} = '0;
    repeat (c)
    begin
      n += sampleReady;
      g += ledGreen + 100 * ledRed;
      tick(1);
    end
  endtask

  task endOfTest();
    $display("Mismatches %0d, checks %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    {hits, cfg, health, teachRequestInput, toolTeachStart, toolTeachField, sampleValid, sampleAngle, sampleDist} = '0;
    {limitRdData, nWr, nMismatch, testsRun, cyc} = '0;
    teachDurationCfg = 8'h09;
    tick(8);
    `CHECK_EQ(statusWord, 16'h0000)
    rst = 1'b0;
    tick(1);
    `CHECK_EQ(statusWord, 16'h0010)
    tick(1);
    `CHECK_EQ({durationRejected, statusWord}, 17'h10020)
    master.send(8'h03, `CMD_SAVE);
    `CHECK_EQ(saveStrobe, 1'b0)
    cfg[1] = 1'b1;
    master.send(`CMD_INDEX, 8'h55);
    `CHECK_EQ({saveStrobe, restoreStrobe, statusWord}, 18'h00030)
    cfg[1] = 1'b0;
    master.send(`CMD_INDEX, `CMD_SAVE);
    `CHECK_EQ(saveStrobe, 1'b1)
    master.send(`CMD_INDEX, `CMD_RESTORE);
    `CHECK_EQ({saveStrobe, restoreStrobe}, 2'b01)
    tick(2);
    `CHECK_EQ(statusWord, 16'h0030)
    for (int f = 0; f < 2; f++)
    begin
      hits = 2'b01 << f;
      tick(2);
      hits = 2'b00;
      tick(3);
      `CHECK_EQ({switchOutputTwo, switchOutputOne, statusWord[1:0]}, {2{2'b01 << f}})
      `CHECK_EQ({counterTwo, counterOne}, 32'h1 << (16 * f))
      master.send(`CMD_INDEX, f ? `CMD_CLR_CNT_F2 : `CMD_CLR_CNT_F1);
      `CHECK_EQ({counterTwo, counterOne}, 32'h0)
      master.send(`CMD_INDEX, f ? `CMD_CLR_RES_F2 : `CMD_CLR_RES_F1);
      `CHECK_EQ({switchOutputTwo, switchOutputOne}, 2'b00)
    end
    for (int i = 0; i < 5; i++)
    begin
      health = 5'b10000 >> i;
      tick(3);
      `CHECK_EQ(statusWord[7:4], 4'(8 - i))
    end
    health = 5'b00000;
    teachDurationCfg = 8'h0A;
    tick(3);
    `CHECK_EQ({durationRejected, statusWord[7:4]}, 5'h03)
    master.send(`CMD_INDEX, `CMD_TEACH_F2);
    t0 = cyc;
    `CHECK_EQ({teachActive, teachField}, 2'b11)
    toolTeachStart = 1'b1;
    tick(1);
    toolTeachStart = 1'b0;
    tick(2);
    `CHECK_EQ({teachActive, teachField}, 2'b11)
    sampleAngle = 9'h078;
    sampleDist = 16'h0100;
    sampleValid = 1'b1;
    greenSum(40);
    sampleValid = 1'b0;
    `CHECK_EQ({n == 40, g > 12 && g < 28}, 2'b11)
    `WAIT_UNTIL(ledRed === 1'b1)
    `CHECK_EQ({ledGreen, (cyc - t0) inside {[298:302]}}, 2'b11)
    `WAIT_UNTIL(ledRed === 1'b0)
    t0 = cyc;
    push(9'h005, 16'd1000);
    push(9'h005, 16'd800);
    push(9'h005, 16'd900);
    push(-9'sd100, 16'd400);
    tick(8);
    `CHECK_EQ(mem[8'h69], 16'd550)
    `CHECK_EQ({mem[8'h00], nWr, limitWrField}, 25'h1_2C09)
    greenSum(40);
    `CHECK_EQ(g > 12 && g < 28, 1'b1)
    `WAIT_UNTIL(teachActive === 1'b0)
    `CHECK_EQ((cyc - t0) inside {[198:202]}, 1'b1)
    tick(2);
    greenSum(20);
    `CHECK_EQ(g, 20)
    teachRequestInput = 1'b1;
    tick(3);
    `CHECK_EQ({teachActive, teachField}, 2'b10)
    `WAIT_UNTIL(ledRed === 1'b1)
    `WAIT_UNTIL(ledRed === 1'b0)
    tick(20);
    `CHECK_EQ(teachActive, 1'b1)
    teachRequestInput = 1'b0;
    tick(3);
    `CHECK_EQ(teachActive, 1'b0)
    {cfg[0], teachRequestInput} = 2'b11;
    tick(3);
    `CHECK_EQ(teachActive, 1'b0)
    endOfTest();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    nMismatch++;
    endOfTest();
  end
endmodule // tb_lidar_link_status_teach
